// File: hw/jtl_pkg.sv
package jtl_pkg;
  // ---------------------------------------------------------------------
  // Link geometry
  // ---------------------------------------------------------------------
  localparam int          LANES_MAX     = 8;
  localparam int          LANE_CNT_W    = 4;
  localparam int          OCT_W         = 8;
  localparam int          CHAR_W        = 10;
  localparam int          BLK_W         = 66;
  localparam int          SMP_W         = 64;
  // Frames per multiframe (K) and octets per frame (F), fixed here
  localparam int          FRAME_OCTETS  = 2;
  localparam int          MF_FRAMES     = 16;
  localparam int          MF_CHARS      = FRAME_OCTETS * MF_FRAMES;
  localparam int          MF_CNT_W      = 8;
  localparam logic [7:0]  MF_LAST       = 8'(MF_CHARS - 1);
  // Blocks per extended multiblock (32 blocks per multiblock, E = 1)
  localparam logic [7:0]  EMB_LAST      = 8'h1F;
  // Index of the last initial lane alignment multiframe (span of four multiframes)
  localparam logic [1:0]  ILA_LAST_MF   = 2'h3;
  // Receiver needs this many commas before it may release sync
  localparam logic [2:0]  CGS_COMMAS    = 3'h4;
  // ---------------------------------------------------------------------
  // Control characters (8-bit data with K flag carried separately)
  // ---------------------------------------------------------------------
  localparam logic [7:0]  K_COMMA       = 8'hBC;
  localparam logic [7:0]  K_ILA_START   = 8'h1C;
  localparam logic [7:0]  K_ILA_END     = 8'h7C;
  localparam logic [7:0]  K_CFG_MARK    = 8'h9C;
  // Block sync headers
  localparam logic [1:0]  SH_DATA       = 2'h1;
  localparam logic [1:0]  SH_CTRL       = 2'h2;
  // ---------------------------------------------------------------------
  // Scrambler seeds (polynomial taps are fixed in the transmitter)
  // ---------------------------------------------------------------------
  localparam logic [14:0] SCR8_SEED     = 15'h7FFF;
  localparam logic [57:0] SCR64_SEED    = 58'h3FF_FFFF_FFFF_FFFF;

  typedef enum logic {JTL_ENC_8B10B, JTL_ENC_64B66B} jtl_enc_t;

  typedef enum {JTL_ST_IDLE, JTL_ST_CGS, JTL_ST_WAIT_MF, JTL_ST_ILA, JTL_ST_DATA} jtl_state_t;
endpackage

// File: hw/jtl_link_if.sv
`timescale 1ns/1ps
// Link between the converter transmitter and the receiving logic
interface jtl_link_if;
  import jtl_pkg::*;
  logic [7:0]  lane_oct  [LANES_MAX];
  logic        lane_k    [LANES_MAX];
  logic [1:0]  lane_sh   [LANES_MAX];
  logic [63:0] lane_blk  [LANES_MAX];
  logic        lane_en   [LANES_MAX];
  logic        enc_mode;
  logic        sync_request_pin;
  logic        sysref;

  modport tx (output lane_oct, lane_k, lane_sh, lane_blk, lane_en, enc_mode,
              input sync_request_pin, sysref);
  modport rx (input lane_oct, lane_k, lane_sh, lane_blk, lane_en, enc_mode,
              output sync_request_pin, sysref);
endinterface

// File: hw/jtl_tx.sv
`timescale 1ns/1ps
module jtl_tx
  import jtl_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  enc_sel_i,
  input  wire logic                  scr_en_i,
  input  wire logic                  fec_en_i,
  input  wire logic                  sync_osc_use_i,
  input  wire logic [jtl_pkg::LANE_CNT_W-1:0] lane_cnt_i,
  input  wire logic [63:0]           smp_data_i,
  input  wire logic                  sysref_i,
  output logic                       smp_ready_o,
  output logic                       osc_sync_o,
  output logic                       fec_active_o,
  output logic                       link_up_o,
  jtl_link_if.tx                     link
);
  import jtl_pkg::*;

  // -------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------
  logic sync_m, sync_s, sync_d;
  logic sref_m, sref_s, sref_d;

  // Two synchronising flip-flops plus an edge-detect flip-flop for pins from the receiver and clock tree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_m <= 1'b1;
      sync_s <= 1'b1;
      sync_d <= 1'b1;
      sref_m <= 1'b0;
      sref_s <= 1'b0;
      sref_d <= 1'b0;
    end else begin
      sync_m <= link.sync_request_pin;
      sync_s <= sync_m;
      sync_d <= sync_s;
      sref_m <= link.sysref;
      sref_s <= sref_m;
      sref_d <= sref_s;
    end
  end

  wire sref_rise = sref_s & ~sref_d;
  wire sync_rise = sync_s & ~sync_d;
  wire mode_64   = (enc_sel_i == JTL_ENC_64B66B);

  // pin only drives the oscillator path in block mode
  assign osc_sync_o   = mode_64 & sync_osc_use_i & sync_rise;
  // FEC only valid alongside block coding
  assign fec_active_o = mode_64 & fec_en_i;

  // -------------------------------------------------------------------
  // Local multiframe / extended multiblock counter
  // -------------------------------------------------------------------
  logic [MF_CNT_W-1:0] lmc;
  wire  [MF_CNT_W-1:0] lmc_last = mode_64 ? EMB_LAST : MF_LAST;
  wire                 lmc_edge = (lmc == lmc_last);

  // SYSREF edge forces counter to phase zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      lmc <= '0;
    else if (sref_rise)
      lmc <= '0;
    else
      lmc <= lmc_edge ? '0 : lmc + 1'b1;
  end

  // -------------------------------------------------------------------
  // Link state machine
  // -------------------------------------------------------------------
  jtl_state_t state, next_state;
  logic [1:0]          ila_mf;
  logic                sref_seen;

  // Subclass 1: no link start before the counter is phased by SYSREF
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      sref_seen <= 1'b0;
    else if (sref_rise)
      sref_seen <= 1'b1;
  end

  // Next state decode
  always_comb begin
    next_state = state;
    case (state)
      JTL_ST_IDLE: begin
        if (sref_seen)
          next_state = mode_64 ? JTL_ST_DATA : JTL_ST_CGS;
      end
      JTL_ST_CGS: begin
        // sync release arms wait for edge
        if (sync_s)
          next_state = JTL_ST_WAIT_MF;
      end
      JTL_ST_WAIT_MF: begin
        if (!sync_s)
          next_state = JTL_ST_CGS;
        else if (lmc_edge)
          next_state = JTL_ST_ILA;
      end
      JTL_ST_ILA: begin
        if (!sync_s)
          next_state = JTL_ST_CGS;
        else if (lmc_edge && ila_mf == ILA_LAST_MF)
          next_state = JTL_ST_DATA;
      end
      JTL_ST_DATA: begin
        // resync request from pin in 8B/10B
        // block mode never returns on pin
        if (!mode_64 && !sync_s)
          next_state = JTL_ST_CGS;
      end
      default: next_state = JTL_ST_IDLE;
    endcase
    if (mode_64 && state != JTL_ST_IDLE)
      next_state = JTL_ST_DATA;
  end

  // State and alignment multiframe count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= JTL_ST_IDLE;
      ila_mf <= '0;
    end else begin
      state  <= next_state;
      if (state != JTL_ST_ILA)
        ila_mf <= '0;
      else if (lmc_edge)
        ila_mf <= ila_mf + 1'b1;
    end
  end

  wire in_data = (state == JTL_ST_DATA);
  assign smp_ready_o = in_data;
  assign link_up_o   = in_data;

  // -------------------------------------------------------------------
  // Scramblers (self-synchronous, 1 + x^14 + x^15 and 1 + x^39 + x^58)
  // -------------------------------------------------------------------
  logic [14:0] scr8;
  logic [57:0] scr64;
  logic [7:0]  scr8_out;
  logic [63:0] scr64_out;

  // Octet and block scramble, combinational over the shift history
  always_comb begin
    logic [22:0] h8;
    logic [121:0] h64;
    h8  = {scr8, 8'h00};
    h64 = {scr64, 64'h0};
    for (int i = 7; i >= 0; i--) begin
      h8[i] = smp_data_i[i] ^ h8[i+14] ^ h8[i+15];
    end
    for (int i = 63; i >= 0; i--) begin
      h64[i] = smp_data_i[i] ^ h64[i+39] ^ h64[i+58];
    end
    scr8_out  = h8[7:0];
    scr64_out = h64[63:0];
  end

  // block mode always scrambles, octet mode by enable
  wire use_scr8 = scr_en_i & ~mode_64;

  // Scrambler history update while data flows
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scr8  <= SCR8_SEED;
      scr64 <= SCR64_SEED;
    end else if (in_data) begin
      scr8  <= {scr8[6:0], scr8_out};
      scr64 <= scr64_out[57:0];
    end
  end

  // -------------------------------------------------------------------
  // Lane output registers
  // -------------------------------------------------------------------
  logic [7:0]  nxt_oct;
  logic        nxt_k;
  wire  [7:0]  data_oct = use_scr8 ? scr8_out : smp_data_i[7:0];

  // commas during CGS, standard alignment characters
  always_comb begin
    nxt_oct = K_COMMA;
    nxt_k   = 1'b1;
    case (state)
      JTL_ST_ILA: begin
        // each multiframe opens /R/ and ends /A/
        if (lmc == '0)
          nxt_oct = K_ILA_START;
        else if (lmc_edge)
          nxt_oct = K_ILA_END;
        else if (ila_mf == 2'h1 && lmc == 8'h01)
          nxt_oct = K_CFG_MARK;
        else begin
          nxt_oct = lmc;
          nxt_k   = 1'b0;
        end
      end
      JTL_ST_DATA: begin
        nxt_oct = data_oct;
        nxt_k   = 1'b0;
      end
      default: begin
        nxt_oct = K_COMMA;
        nxt_k   = 1'b1;
      end
    endcase
  end

  // block coding only, plain 64B/66B headers, no CRC bits
  wire [1:0] nxt_sh = in_data ? SH_DATA : SH_CTRL;

  // one shared stream, gated per configured lane
  for (genvar g = 0; g < LANES_MAX; g++) begin : g_lane
    wire lane_on = (LANE_CNT_W'(g) < lane_cnt_i) && (state != JTL_ST_IDLE);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        link.lane_oct[g] <= '0;
        link.lane_k[g]   <= 1'b0;
        link.lane_sh[g]  <= '0;
        link.lane_blk[g] <= '0;
        link.lane_en[g]  <= 1'b0;
      end else begin
        link.lane_en[g]  <= lane_on;
        link.lane_oct[g] <= (lane_on && !mode_64) ? nxt_oct : 8'h00;
        link.lane_k[g]   <= lane_on && !mode_64 && nxt_k;
        link.lane_sh[g]  <= (lane_on && mode_64) ? nxt_sh : 2'h0;
        link.lane_blk[g] <= (lane_on && mode_64 && in_data) ? scr64_out : 64'h0;
      end
    end
  end

  // Coding mode reported to the receiver
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      link.enc_mode <= 1'b0;
    else
      link.enc_mode <= enc_sel_i;
  end
  // no multipoint reference; pin sampled as plain level
endmodule

// File: hw/jtl_rx.sv
`timescale 1ns/1ps
module jtl_rx
  import jtl_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  link_req_i,
  input  wire logic                  sysref_i,
  output logic                       cgs_done_o,
  output logic                       ila_seen_o,
  output logic                       blk_lock_o,
  output logic [63:0]                lane0_data_o,
  jtl_link_if.rx                     link
);
  import jtl_pkg::*;

  // -------------------------------------------------------------------
  // Receiver local multiframe counter and comma count
  // -------------------------------------------------------------------
  logic [MF_CNT_W-1:0] lmc;
  logic [2:0]          commas;
  logic                sync_n;
  wire                 lmc_edge = (lmc == MF_LAST);
  wire                 is_comma = link.lane_k[0] && link.lane_oct[0] == K_COMMA;

  // drive sync low while requesting, release on multiframe edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lmc    <= '0;
      commas <= '0;
      sync_n <= 1'b0;
    end else begin
      lmc <= (sysref_i || lmc_edge) ? '0 : lmc + 1'b1;
      if (!link_req_i) begin
        commas <= '0;
        sync_n <= 1'b0;
      end else if (link.enc_mode) begin
        // block mode has no commas, pin only follows the request
        sync_n <= 1'b1;
      end else if (is_comma && commas != CGS_COMMAS) begin
        commas <= commas + 1'b1;
      end else if (commas == CGS_COMMAS && lmc_edge) begin
        sync_n <= 1'b1;
      end
    end
  end

  // block lock purely from sync headers, pin not consulted
  logic blk_lock;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_lock     <= 1'b0;
      ila_seen_o   <= 1'b0;
      lane0_data_o <= '0;
    end else begin
      blk_lock <= link.enc_mode &&
                  (link.lane_sh[0] == SH_DATA || link.lane_sh[0] == SH_CTRL);
      if (link.lane_k[0] && link.lane_oct[0] == K_ILA_START)
        ila_seen_o <= 1'b1;
      else if (!sync_n)
        ila_seen_o <= 1'b0;
      lane0_data_o <= link.enc_mode ? link.lane_blk[0] : {56'h0, link.lane_oct[0]};
    end
  end

  assign blk_lock_o            = blk_lock;
  assign cgs_done_o            = (commas == CGS_COMMAS);
  assign link.sync_request_pin = sync_n;
  assign link.sysref           = sysref_i;
endmodule

// File: test/jtl_link_sva.sv
`timescale 1ns/1ps
module jtl_link_sva
  import jtl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  lane_oct [jtl_pkg::LANES_MAX],
  input wire logic        lane_k   [jtl_pkg::LANES_MAX],
  input wire logic [1:0]  lane_sh  [jtl_pkg::LANES_MAX],
  input wire logic [63:0] lane_blk [jtl_pkg::LANES_MAX],
  input wire logic        lane_en  [jtl_pkg::LANES_MAX],
  input wire logic        enc_mode,
  input wire logic        sync_request_pin,
  input wire logic        sysref
);
  import jtl_pkg::*;

  // ------------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------------
  logic [7:0] en_vec;
  logic       lane_mis;
  // Packed lane enables, and any enabled lane differing from lane 0
  always_comb begin
    lane_mis = 1'b0;
    for (int i = 0; i < LANES_MAX; i++) begin
      en_vec[i] = lane_en[i];
      if (lane_en[i] && (lane_oct[i] != lane_oct[0] || lane_k[i] != lane_k[0]))
        lane_mis = 1'b1;
    end
  end
  // Start-of-multiframe marker of the alignment sequence on lane 0
  wire ila_r = lane_en[0] && !enc_mode && lane_k[0] && lane_oct[0] == K_ILA_START;

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  comma_stream_a: assert property (
    (!sync_request_pin) [*6] ##0 (lane_en[0] && !enc_mode) |-> lane_k[0] && lane_oct[0] == K_COMMA)
    else $error("comma not sent while sync request low");
  comma_lanes_a: assert property (
    (!sync_request_pin) [*6] ##0 (lane_en[0] && !enc_mode) |-> !lane_mis)
    else $error("lanes differ during comma stream");
  lanes_aligned_a: assert property (ila_r |-> !lane_mis)
    else $error("lanes not aligned at alignment start");
  header_valid_a: assert property (
    enc_mode && lane_en[0] |-> lane_sh[0] == SH_DATA || lane_sh[0] == SH_CTRL)
    else $error("invalid block sync header");
  lanes_packed_a: assert property (((en_vec + 8'h01) & en_vec) == 8'h00)
    else $error("enabled lanes not contiguous from lane 0");
  ila_frame_a: assert property (
    ila_r |-> ##31 (lane_k[0] && lane_oct[0] == K_ILA_END))
    else $error("multiframe end marker missing");
  ila_span_a: assert property (
    ila_r && !$past(ila_r, 32) |-> ##32 ila_r ##32 ila_r ##32 ila_r ##32 !ila_r)
    else $error("alignment sequence not four multiframes");
  ila_after_sync_a: assert property (ila_r |-> $past(sync_request_pin, 3))
    else $error("alignment started before sync release");

  cover property (ila_r);
  cover property (enc_mode && lane_en[0]);
  cover property (en_vec == 8'hFF);
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import jtl_pkg::*;
  logic        clk_i, rst_n_i, enc_sel_i, scr_en_i, fec_en_i, sync_osc_use_i;
  logic [3:0]  lane_cnt_i;
  logic [63:0] smp_data_i, lane0_data_o, blk_a;
  logic        sysref_i, link_req_i, smp_ready_o, osc_sync_o, fec_active_o, link_up_o;
  logic        cgs_done_o, ila_seen_o, blk_lock_o;
  logic        up_d1 = 1'b0;
  logic        up_d2 = 1'b0;
  logic [7:0]  en_vec;
  logic [8:0]  note_q [$];
  int          err_count, checks_done, n_osc;
  int          seed = 67;
  // Case table: encoding, FEC, scramble, oscillator use, lanes (0 = random)
  logic [7:0]  cfg [6] = '{8'h48, 8'h21, 8'h00, 8'hD4, 8'h80, 8'h98};

  jtl_link_if link_if ();
  jtl_tx jtl_tx_i (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .enc_sel_i      (enc_sel_i),
    .scr_en_i       (scr_en_i),
    .fec_en_i       (fec_en_i),
    .sync_osc_use_i (sync_osc_use_i),
    .lane_cnt_i     (lane_cnt_i),
    .smp_data_i     (smp_data_i),
    .sysref_i       (sysref_i),
    .smp_ready_o    (smp_ready_o),
    .osc_sync_o     (osc_sync_o),
    .fec_active_o   (fec_active_o),
    .link_up_o      (link_up_o),
    .link           (link_if)
  );
  jtl_rx jtl_rx_i (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .link_req_i   (link_req_i),
    .sysref_i     (sysref_i),
    .cgs_done_o   (cgs_done_o),
    .ila_seen_o   (ila_seen_o),
    .blk_lock_o   (blk_lock_o),
    .lane0_data_o (lane0_data_o),
    .link         (link_if)
  );
  jtl_link_sva jtl_link_sva_i (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .lane_oct         (link_if.lane_oct),
    .lane_k           (link_if.lane_k),
    .lane_sh          (link_if.lane_sh),
    .lane_blk         (link_if.lane_blk),
    .lane_en          (link_if.lane_en),
    .enc_mode         (link_if.enc_mode),
    .sync_request_pin (link_if.sync_request_pin),
    .sysref           (link_if.sysref)
  );

  // ------------------------------------------------------------------
  // Clock, helpers and result monitor
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always_comb for (int i = 0; i < LANES_MAX; i++) en_vec[i] = link_if.lane_en[i];

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? link_up_o : blk_lock_o;
  endfunction
  // Bounded wait for link up (0) or block lock (1)
  task automatic wait_on(input int w, input logic want);
    int i;
    for (i = 0; i < 600 && pick(w) !== want; i++) step(1);
    if (i == 600) begin
      err_count++;
      $display("CHECK FAILED wait %0d expected %b seen %b", w, want, pick(w));
      wrap_up();
    end
  endtask
  // Oldest note compared once the link has been up for a cycle
  always @(posedge clk_i) begin
    up_d1 <= link_up_o;
    up_d2 <= up_d1;
    if (up_d1 && !up_d2) begin
      if (note_q.size() == 0) check("note queue", 64'h1, 64'h0);
      else check("lanes fec", 64'(note_q.pop_front()), {55'h0, fec_active_o, en_vec});
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] c;
    logic [8:0] note;
    logic       enc;
    int         lanes;
    sysref_i = 1'b0;
    link_req_i = 1'b0;
    {enc_sel_i, scr_en_i, fec_en_i, sync_osc_use_i} = 4'h0;
    lane_cnt_i = 4'h0;
    smp_data_i = 64'h0;
    for (int k = 0; k < 6; k++) begin
      c = cfg[k];
      enc = c[7];
      lanes = c[3:0] == 4'h0 ? 1 + $unsigned($random(seed)) % 8 : int'(c[3:0]);
      rst_n_i = 1'b0;
      link_req_i = 1'b0;
      step(12);
      {enc_sel_i, fec_en_i, scr_en_i, sync_osc_use_i} = c[7:4];
      lane_cnt_i = 4'(lanes);
      smp_data_i = {$random(seed), $random(seed)};
      note = {enc & c[6], 8'((9'h001 << lanes) - 9'h001)};
      note_q.push_back(note);
      rst_n_i = 1'b1;
      step(2);
      sysref_i = 1'b1;
      step(2);
      sysref_i = 1'b0;
      step(40);
      link_req_i = !enc;
      step(8);
      if (!enc) check("cgs_done_o", 64'h1, 64'(cgs_done_o));
      wait_on(0, 1'b1);
      check("smp_ready_o", 64'h1, 64'(smp_ready_o));
      if (!enc) begin
        check("ila_seen_o", 64'h1, 64'(ila_seen_o));
        step(3);
        if (!c[5]) check("lane0_data_o", {56'h0, smp_data_i[7:0]}, lane0_data_o);
        link_req_i = 1'b0;
        wait_on(0, 1'b0);
        step(20);
        note_q.push_back(note);
        link_req_i = 1'b1;
        wait_on(0, 1'b1);
      end else begin
        wait_on(1, 1'b1);
        blk_a = link_if.lane_blk[0];
        step(1);
        check("blk changes", 64'h1, 64'(blk_a !== link_if.lane_blk[0]));
        check("blk scrambled", 64'h1, 64'(blk_a !== smp_data_i));
        link_req_i = 1'b1;
        n_osc = 0;
        for (int i = 0; i < 12; i++) begin
          step(1);
          n_osc += int'(osc_sync_o);
        end
        check("osc pulse", 64'(c[4]), 64'(n_osc != 0));
        check("link_up_o", 64'h1, 64'(link_up_o));
      end
      step(40);
      $display("test %0d done", k);
    end
    check("notes left", 64'h0, 64'(note_q.size()));
    wrap_up();
  end
endmodule
